// ==== logic/tmr_timer16.sv ====
// Module: 16-bit timer counter, control/status and channel 0 capture/compare
`timescale 1ns/1ps
module tmr_timer16
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_tick,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic [15:0] i_ch0_compare_value,
    input  wire logic        i_capture_pin,
    input  wire logic        i_radio_event,
    input  wire logic        i_ch1_event,
    input  wire logic        i_ch2_event,
    input  wire logic [2:0]  i_other_irq_mask,
    output logic      [15:0] o_counter_value,
    output logic      [15:0] o_ch0_capture_value,
    output logic             o_ch0_output,
    output logic             o_irq_pulse
);
    import tmr_pkg::*;

    // ==========================================
    // Registers
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        down_reg;
    logic        down_next;
    logic [7:0]  high_buf_reg;
    logic [3:0]  flag_reg;
    logic [3:0]  flag_next;
    logic [3:0]  flag_set;
    logic [1:0]  div_reg;
    logic [1:0]  mode_reg;
    logic [7:0]  ch0_ctl_reg;
    logic [6:0]  pre_reg;
    logic        cap_s1_reg;
    logic        cap_s2_reg;
    logic        cap_s3_reg;
    logic [3:0]  mask_prev_reg;
    logic        out_reg;

    logic        wr_low;
    logic        wr_ctl;
    logic        wr_ch0;
    logic        rd_low;
    logic        step;
    logic        ovf_evt;
    logic        zero_turn;
    logic        match;
    logic        match_up;
    logic        at_zero;
    logic        cap_edge;
    logic        cap_evt;
    logic        cmp_mode;
    logic [3:0]  mask_all;
    tmr_mode_t   mode;
    tmr_div_t    div;
    tmr_act_t    act;
    logic [1:0]  edge_sel;

    assign mode     = tmr_mode_t'(mode_reg);
    assign div      = tmr_div_t'(div_reg);
    assign act      = tmr_act_t'(ch0_ctl_reg[TMR_ACT_HI:TMR_ACT_LO]);
    assign edge_sel = ch0_ctl_reg[TMR_EDGE_HI:TMR_EDGE_LO];
    assign cmp_mode = ch0_ctl_reg[TMR_CMPMODE_BIT];
    assign wr_low   = i_wr && (i_addr == TMR_ADDR_CNT_LOW);
    assign wr_ctl   = i_wr && (i_addr == TMR_ADDR_CTL_STS);
    assign wr_ch0   = i_wr && (i_addr == TMR_ADDR_CH0_CTL);
    assign rd_low   = i_rd && (i_addr == TMR_ADDR_CNT_LOW);

    // ==========================================
    // Prescaler
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pre_reg <= '0;
        else if (i_tick)
            pre_reg <= pre_reg + TMR_PRE_STEP;
    end

    always_comb
    begin
        step = 1'b0;
        unique case (div)
            TMR_DIV_1:   step = i_tick;
            TMR_DIV_8:   step = i_tick && (pre_reg[2:0] == TMR_PRE_END8[2:0]);
            TMR_DIV_32:  step = i_tick && (pre_reg[4:0] == TMR_PRE_END32[4:0]);
            TMR_DIV_128: step = i_tick && (pre_reg == TMR_PRE_END128);
        endcase
    end

    // ==========================================
    // Counter
    always_comb
    begin
        cnt_next  = cnt_reg;
        down_next = down_reg;
        ovf_evt   = 1'b0;
        zero_turn = 1'b0;
        unique case (mode)
            TMR_MODE_STOP:
            begin
                cnt_next = cnt_reg;
            end
            TMR_MODE_FREE:
            begin
                cnt_next = cnt_reg + TMR_CNT_ONE;
                ovf_evt  = (cnt_reg == TMR_CNT_MAX);
                down_next = 1'b0;
            end
            TMR_MODE_MOD:
            begin
                down_next = 1'b0;
                if (cnt_reg >= i_ch0_compare_value)
                begin
                    cnt_next = TMR_CNT_ZERO;
                    ovf_evt  = 1'b1;
                end
                else
                    cnt_next = cnt_reg + TMR_CNT_ONE;
            end
            TMR_MODE_UPDN:
            begin
                if (down_reg)
                begin
                    if (cnt_reg == TMR_CNT_ZERO)
                    begin
                        down_next = 1'b0;
                        cnt_next  = TMR_CNT_ONE;
                        ovf_evt   = 1'b1;
                        zero_turn = 1'b1;
                    end
                    else
                        cnt_next = cnt_reg - TMR_CNT_ONE;
                end
                else if (cnt_reg >= i_ch0_compare_value)
                begin
                    down_next = 1'b1;
                    if (cnt_reg != TMR_CNT_ZERO)
                        cnt_next = cnt_reg - TMR_CNT_ONE;
                end
                else
                    cnt_next = cnt_reg + TMR_CNT_ONE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_reg  <= TMR_CNT_ZERO;
            down_reg <= 1'b0;
        end
        else if (wr_low)
        begin
            cnt_reg  <= TMR_CNT_ZERO;
            down_reg <= 1'b0;
        end
        else if (step && (mode != TMR_MODE_STOP))
        begin
            cnt_reg  <= cnt_next;
            down_reg <= down_next;
        end
    end

    // ==========================================
    // Compare events, taken when the count lands on a value
    assign match    = step && (mode != TMR_MODE_STOP) && !wr_low
                      && (cnt_next == i_ch0_compare_value);
    assign match_up = match && !down_next;
    assign at_zero  = step && (mode != TMR_MODE_STOP) && !wr_low
                      && (cnt_next == TMR_CNT_ZERO);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            out_reg <= 1'b0;
        else if (cmp_mode)
        begin
            unique case (act)
                TMR_ACT_SET:
                begin
                    if (match)
                        out_reg <= 1'b1;
                end
                TMR_ACT_CLR:
                begin
                    if (match)
                        out_reg <= 1'b0;
                end
                TMR_ACT_TGL:
                begin
                    if (match)
                        out_reg <= !out_reg;
                end
                TMR_ACT_SETUP:
                begin
                    if (match_up)
                        out_reg <= 1'b1;
                    else if (mode == TMR_MODE_UPDN ? (match && down_next) : at_zero)
                        out_reg <= 1'b0;
                end
                TMR_ACT_CLRUP:
                begin
                    if (match_up)
                        out_reg <= 1'b0;
                    else if (mode == TMR_MODE_UPDN ? (match && down_next) : at_zero)
                        out_reg <= 1'b1;
                end
                default:
                begin
                    out_reg <= out_reg;
                end
            endcase
        end
    end

    // ==========================================
    // Capture input synchroniser and edge detect
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cap_s1_reg <= 1'b0;
            cap_s2_reg <= 1'b0;
            cap_s3_reg <= 1'b0;
        end
        else
        begin
            cap_s1_reg <= i_capture_pin;
            cap_s2_reg <= cap_s1_reg;
            cap_s3_reg <= cap_s2_reg;
        end
    end

    always_comb
    begin
        cap_edge = 1'b0;
        unique case (edge_sel)
            TMR_EDGE_NONE: cap_edge = 1'b0;
            TMR_EDGE_RISE: cap_edge = cap_s2_reg && !cap_s3_reg;
            TMR_EDGE_FALL: cap_edge = !cap_s2_reg && cap_s3_reg;
            TMR_EDGE_BOTH: cap_edge = cap_s2_reg != cap_s3_reg;
        endcase
    end

    assign cap_evt = !cmp_mode && (ch0_ctl_reg[TMR_SRC_BIT]
                     ? (i_radio_event && (edge_sel != TMR_EDGE_NONE))
                     : cap_edge);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_ch0_capture_value <= TMR_CNT_ZERO;
        else if (cap_evt)
            o_ch0_capture_value <= cnt_reg;
    end

    // ==========================================
    // Event flags
    always_comb
    begin
        flag_set    = '0;
        flag_set[0] = ovf_evt && step;
        flag_set[3] = i_ch2_event;
        flag_set[2] = i_ch1_event;
        if (cmp_mode)
            flag_set[1] = (mode == TMR_MODE_UPDN) ? (zero_turn && step && !wr_low) : match;
        else
            flag_set[1] = cap_evt;
        if (wr_low)
            flag_set[0] = 1'b0;
    end

    always_comb
    begin
        flag_next = flag_reg;
        if (wr_ctl)
            flag_next = flag_reg & {i_wdata[TMR_CH2_FLAG_BIT], i_wdata[TMR_CH1_FLAG_BIT],
                                    i_wdata[TMR_CH0_FLAG_BIT], i_wdata[TMR_OVF_FLAG_BIT]};
        flag_next = flag_next | flag_set;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            flag_reg <= '0;
        else
            flag_reg <= flag_next;
    end

    // ==========================================
    // Control registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div_reg  <= TMR_RST_CTL_STS[TMR_DIV_HI:TMR_DIV_LO];
            mode_reg <= TMR_RST_CTL_STS[TMR_MODE_HI:TMR_MODE_LO];
        end
        else if (wr_ctl)
        begin
            div_reg  <= i_wdata[TMR_DIV_HI:TMR_DIV_LO];
            mode_reg <= i_wdata[TMR_MODE_HI:TMR_MODE_LO];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ch0_ctl_reg <= TMR_RST_CH0_CTL;
        else if (wr_ch0)
            ch0_ctl_reg <= i_wdata;
    end

    // ==========================================
    // Interrupt request pulse
    assign mask_all = {i_other_irq_mask[1], i_other_irq_mask[0],
                       ch0_ctl_reg[TMR_MASK_BIT], i_other_irq_mask[2]};

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mask_prev_reg <= '0;
            o_irq_pulse   <= 1'b0;
        end
        else
        begin
            mask_prev_reg <= mask_all;
            o_irq_pulse   <= |(flag_set & mask_all)
                             | |(mask_all & ~mask_prev_reg & flag_reg);
        end
    end

    // ==========================================
    // Read port
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            high_buf_reg <= '0;
        else if (rd_low)
            high_buf_reg <= cnt_reg[15:8];
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= '0;
        else if (i_rd)
        begin
            unique case (i_addr)
                TMR_ADDR_CNT_LOW:  o_rdata <= cnt_reg[7:0];
                TMR_ADDR_CNT_HIGH: o_rdata <= high_buf_reg;
                TMR_ADDR_CTL_STS:  o_rdata <= {flag_reg, div_reg, mode_reg};
                TMR_ADDR_CH0_CTL:  o_rdata <= ch0_ctl_reg;
                default:           o_rdata <= '0;
            endcase
        end
        else
            o_rdata <= '0;
    end

    assign o_counter_value = cnt_reg;
    assign o_ch0_output    = out_reg;
endmodule

// ==== logic/tmr_pkg.sv ====
// Package: register map, fields and encodings of the 16-bit timer
package tmr_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] TMR_ADDR_CNT_LOW  = 8'he2;
    localparam logic [7:0] TMR_ADDR_CNT_HIGH = 8'he3;
    localparam logic [7:0] TMR_ADDR_CTL_STS  = 8'he4;
    localparam logic [7:0] TMR_ADDR_CH0_CTL  = 8'he5;
    // ==========================================
    // Reset values and counter constants
    localparam logic [7:0]  TMR_RST_CTL_STS = 8'h00;
    localparam logic [7:0]  TMR_RST_CH0_CTL = 8'h40;
    localparam logic [15:0] TMR_CNT_ZERO    = 16'h0000;
    localparam logic [15:0] TMR_CNT_MAX     = 16'hffff;
    localparam logic [15:0] TMR_CNT_ONE     = 16'h0001;
    // ==========================================
    // Control/status fields
    localparam int TMR_CH2_FLAG_BIT = 7;
    localparam int TMR_CH1_FLAG_BIT = 6;
    localparam int TMR_CH0_FLAG_BIT = 5;
    localparam int TMR_OVF_FLAG_BIT = 4;
    localparam int TMR_DIV_HI       = 3;
    localparam int TMR_DIV_LO       = 2;
    localparam int TMR_MODE_HI      = 1;
    localparam int TMR_MODE_LO      = 0;
    // ==========================================
    // Channel 0 control fields
    localparam int TMR_SRC_BIT    = 7;
    localparam int TMR_MASK_BIT   = 6;
    localparam int TMR_ACT_HI     = 5;
    localparam int TMR_ACT_LO     = 3;
    localparam int TMR_CMPMODE_BIT = 2;
    localparam int TMR_EDGE_HI    = 1;
    localparam int TMR_EDGE_LO    = 0;
    // ==========================================
    // Prescaler
    localparam int         TMR_PRE_W     = 7;
    localparam logic [6:0] TMR_PRE_END8  = 7'h07;
    localparam logic [6:0] TMR_PRE_END32 = 7'h1f;
    localparam logic [6:0] TMR_PRE_END128 = 7'h7f;
    localparam logic [6:0] TMR_PRE_STEP  = 7'h01;
    // ==========================================
    // Encodings
    typedef enum logic [1:0] {TMR_MODE_STOP = 2'h0, TMR_MODE_FREE = 2'h1,
                              TMR_MODE_MOD = 2'h2, TMR_MODE_UPDN = 2'h3} tmr_mode_t;
    typedef enum logic [1:0] {TMR_DIV_1 = 2'h0, TMR_DIV_8 = 2'h1,
                              TMR_DIV_32 = 2'h2, TMR_DIV_128 = 2'h3} tmr_div_t;
    typedef enum logic [2:0] {TMR_ACT_SET = 3'h0, TMR_ACT_CLR = 3'h1, TMR_ACT_TGL = 3'h2,
                              TMR_ACT_SETUP = 3'h3, TMR_ACT_CLRUP = 3'h4} tmr_act_t;
    localparam logic [1:0] TMR_EDGE_NONE = 2'h0;
    localparam logic [1:0] TMR_EDGE_RISE = 2'h1;
    localparam logic [1:0] TMR_EDGE_FALL = 2'h2;
    localparam logic [1:0] TMR_EDGE_BOTH = 2'h3;
endpackage

// ==== sim/tmr_timer16_monitor.sv ====
// Checker: port assertions of the 16-bit timer
`timescale 1ns/1ps
module tmr_timer16_monitor
(
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_tick,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic [15:0] i_ch0_compare_value,
    input wire logic [15:0] o_counter_value,
    input wire logic        o_ch0_output
);
    import tmr_pkg::*;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // Shadow of control registers
    logic [7:0] ctl_reg;
    logic [7:0] ch0_reg;
    logic       clr;
    logic       step;
    assign clr  = i_wr && i_addr == TMR_ADDR_CNT_LOW;
    assign step = i_tick && ctl_reg[3:2] == 2'h0 && !clr;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctl_reg <= TMR_RST_CTL_STS;
            ch0_reg <= TMR_RST_CH0_CTL;
        end
        else if (i_wr && i_addr == TMR_ADDR_CTL_STS)
            ctl_reg <= i_wdata;
        else if (i_wr && i_addr == TMR_ADDR_CH0_CTL)
            ch0_reg <= i_wdata;
    end
    // ==========================================
    // Assertions
    chk_low_read: assert property (i_rd && i_addr == TMR_ADDR_CNT_LOW
        |=> o_rdata == $past(o_counter_value[7:0])) else $error("low byte read wrong");
    chk_high_buffer: assert property (i_rd && i_addr == TMR_ADDR_CNT_LOW
        ##1 i_rd && i_addr == TMR_ADDR_CNT_HIGH
        |=> o_rdata == $past(o_counter_value[15:8], 2)) else $error("high buffer wrong");
    chk_low_clear: assert property (clr |=> o_counter_value == TMR_CNT_ZERO)
        else $error("count not cleared");
    chk_stop_hold: assert property (ctl_reg[1:0] == 2'h0 && !clr
        |=> $stable(o_counter_value)) else $error("stopped count moved");
    chk_free_step: assert property (ctl_reg[1:0] == 2'h1 && step
        |=> o_counter_value == $past(o_counter_value) + 16'h0001) else $error("free step wrong");
    chk_modulo_wrap: assert property (ctl_reg[1:0] == 2'h2 && step
        && o_counter_value >= i_ch0_compare_value |=> o_counter_value == 16'h0000)
        else $error("modulo restart wrong");
    chk_tick_hold: assert property (!i_tick && !clr |=> $stable(o_counter_value))
        else $error("count moved without tick");
    chk_compare_set: assert property (ctl_reg[1:0] == 2'h2 && step && ch0_reg[5:2] == 4'h1
        && o_counter_value + 16'h0001 == i_ch0_compare_value |=> o_ch0_output)
        else $error("compare set missed");
endmodule
bind tmr_timer16 tmr_timer16_monitor mon_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tick(i_tick),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ch0_compare_value(i_ch0_compare_value), .o_counter_value(o_counter_value),
    .o_ch0_output(o_ch0_output));

// ==== sim/tmr_timer16_test.sv ====
// Bench: self-checking test of the 16-bit timer
`timescale 1ns/1ps
module tmr_timer16_test;
    import tmr_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        pin = 1'b0, radio = 1'b0, ev1 = 1'b0, ev2 = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [2:0]  omask = 3'h0;
    logic [15:0] cmp = 16'h0004, seed = 16'h5823, v, c, expc, cnt, cap;
    logic        out, irq;
    int          errors = 0, checked = 0, cyc = 0, irqs = 0, n0, k;
    localparam logic [4:0]  ACTS  = 5'b01101;
    localparam logic [14:0] ORDER = {3'h0, 3'h3, 3'h1, 3'h4, 3'h2};
    tmr_timer16 dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_tick(tick), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ch0_compare_value(cmp),
        .i_capture_pin(pin), .i_radio_event(radio), .i_ch1_event(ev1), .i_ch2_event(ev2),
        .i_other_irq_mask(omask), .o_counter_value(cnt), .o_ch0_capture_value(cap),
        .o_ch0_output(out), .o_irq_pulse(irq));
    initial forever #2.5 clk = ~clk;
    // ==========================================
    // Watchdog and interrupt pulse count
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        irqs <= irqs + int'(irq === 1'b1);
        if (cyc == 90000)
        begin
            errors = errors + 1;
            report_and_stop();
        end
    end
    // ==========================================
    // Helpers
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction
    function automatic int div_ratio(input int d);
        return (d == 0) ? 1 : 1 << (1 + 2 * d);
    endfunction
    task automatic report_and_stop();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic chk_cnt(input logic [15:0] exp);
        logic [15:0] val;
        @(posedge clk);
        addr <= TMR_ADDR_CNT_LOW;
        rd   <= 1'b1;
        @(posedge clk);
        addr <= TMR_ADDR_CNT_HIGH;
        #1 val[7:0] = rdata;
        @(posedge clk);
        rd   <= 1'b0;
        #1 val[15:8] = rdata;
        check(val, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk) tick <= 1'b1;
        @(posedge clk) tick <= 1'b0;
    endtask
    task automatic clear_cnt();
        logic [15:0] r;
        r = rnd();
        wr_reg(TMR_ADDR_CNT_LOW, r[7:0]);
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(TMR_ADDR_CNT_HIGH, 8'h00);
        chk_reg(TMR_ADDR_CTL_STS, TMR_RST_CTL_STS);
        chk_reg(TMR_ADDR_CH0_CTL, TMR_RST_CH0_CTL);
        chk_reg(8'h10, 8'h00);
        ticks(10);
        chk_cnt(16'h0000);
        wr_reg(TMR_ADDR_CTL_STS, 8'h01);
        ticks(255);
        chk_reg(TMR_ADDR_CNT_LOW, 8'hff);
        ticks(1);
        chk_reg(TMR_ADDR_CNT_HIGH, 8'h00);
        chk_cnt(16'h0100);
        clear_cnt();
        chk_cnt(16'h0000);
        for (int d = 0; d < 4; d++)
        begin
            wr_reg(TMR_ADDR_CTL_STS, 8'(d * 4 + 1));
            clear_cnt();
            ticks(div_ratio(d) * 3);
            chk_cnt(16'h0003);
        end
        wr_reg(TMR_ADDR_CTL_STS, 8'h01);
        clear_cnt();
        ticks(65535);
        chk_cnt(TMR_CNT_MAX);
        ticks(1);
        chk_cnt(16'h0000);
        chk_reg(TMR_ADDR_CTL_STS, 8'h11);
        wr_reg(TMR_ADDR_CTL_STS, 8'hf1);
        chk_reg(TMR_ADDR_CTL_STS, 8'h11);
        wr_reg(TMR_ADDR_CTL_STS, 8'h02);
        chk_reg(TMR_ADDR_CTL_STS, 8'h02);
        v = rnd();
        c = 16'(v[4:0]) + 16'h0003;
        @(posedge clk);
        cmp <= c;
        clear_cnt();
        ticks(int'(c));
        chk_cnt(c);
        ticks(1);
        chk_cnt(16'h0000);
        chk_reg(TMR_ADDR_CTL_STS, 8'h12);
        wr_reg(TMR_ADDR_CTL_STS, 8'h03);
        clear_cnt();
        ticks(int'(c) + 1);
        chk_cnt(c - 16'h0001);
        ticks(int'(c) - 1);
        chk_cnt(16'h0000);
        wr_reg(TMR_ADDR_CTL_STS, 8'h03);
        ticks(1);
        chk_reg(TMR_ADDR_CTL_STS, 8'h13);
        wr_reg(TMR_ADDR_CTL_STS, 8'h02);
        for (int a = 0; a < 5; a++)
        begin
            k = int'(ORDER[3 * a +: 3]);
            wr_reg(TMR_ADDR_CH0_CTL, 8'(8'h44 | (k << 3)));
            clear_cnt();
            ticks(int'(c));
            #1;
            check(16'(out), 16'(ACTS[k]));
            if (k > 2)
            begin
                ticks(1);
                #1;
                check(16'(out), 16'(!ACTS[k]));
            end
        end
        wr_reg(TMR_ADDR_CTL_STS, 8'h00);
        n0 = irqs;
        ev2 <= 1'b1;
        @(posedge clk) ev2 <= 1'b0;
        repeat (4) @(posedge clk);
        check(16'(irqs - n0), 16'h0000);
        chk_reg(TMR_ADDR_CTL_STS, 8'h80);
        @(posedge clk);
        omask <= 3'h2;
        repeat (4) @(posedge clk);
        check(16'(irqs - n0), 16'h0001);
        @(posedge clk);
        addr  <= TMR_ADDR_CTL_STS;
        wdata <= 8'h00;
        wr    <= 1'b1;
        ev1   <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        ev1   <= 1'b0;
        chk_reg(TMR_ADDR_CTL_STS, 8'h40);
        wr_reg(TMR_ADDR_CTL_STS, 8'h01);
        expc = 16'h0000;
        for (int e = 0; e < 4; e++)
        begin
            wr_reg(TMR_ADDR_CH0_CTL, 8'(8'h40 | e));
            clear_cnt();
            ticks(e + 4);
            pin <= 1'b1;
            repeat (5) @(posedge clk);
            if (e % 2 == 1)
                expc = 16'(e + 4);
            check(cap, expc);
            ticks(2);
            pin <= 1'b0;
            repeat (5) @(posedge clk);
            if (e > 1)
                expc = 16'(e + 6);
            check(cap, expc);
        end
        wr_reg(TMR_ADDR_CH0_CTL, 8'hc1);
        clear_cnt();
        ticks(20);
        pin <= 1'b1;
        repeat (5) @(posedge clk);
        check(cap, expc);
        radio <= 1'b1;
        @(posedge clk) radio <= 1'b0;
        repeat (5) @(posedge clk);
        check(cap, 16'h0014);
        report_and_stop();
    end
endmodule
